// File: rtl/tsrc_pkg.sv
// Overview of operation
// - Pointer byte bits 1:0 pick one of four data registers; upper bits ignored.
// - Pointer 00h selects the read-only two-byte reading, reset 0000h.
// - Pointer latches on any command carrying it; later bare reads reuse it.
// - Pointer is zero after power-up, so bare reads return the reading.
// - Each finished conversion stores a 12-bit two's complement result, 1/16 degree.
// - Reading shows zero degrees after reset until the first conversion ends.
// - First byte holds result bits 11..4; second byte bits 3..0 then zeros.
// - Reading access returns sixteen bits, upper byte first; controller takes both.
// - Setup byte bits 7..0: trigger, period, fault count, sense, latching, power-down.
// - Pointer 01h selects the read/write setup register, reset 28h.
// - Pointer 02h selects the read/write lower limit, reset 4B00h.
// - Pointer 03h selects the read/write upper limit, reset 5000h.
// - Power-down set: finish the current conversion, then stop converting.
// - Power-down clear: convert continuously, back to back.
// - Latching bit one gives interrupt behaviour, zero comparator behaviour.
// - Sense bit zero makes the alert active low, one active high.
// - Fault-count field 00,01,10,11 needs 1,2,4,6 consecutive faults.
// - Results beyond the limits count as faults; alert after enough in a row.
// - Period field 00..11 selects 27.5, 55, 110 or 220 ms conversions.
// - One-shot written while powered down runs one conversion; reads as zero.
// - Comparator alert asserts at or above upper, clears below lower likewise.
// - Interrupt alert holds until a register read, alert acknowledge or power-down.
package tsrc_pkg;
	// ----------------------------------------------------------------
	// Register selection and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] PTR_READING = 2'h0;
	localparam logic [1:0] PTR_SETUP = 2'h1;
	localparam logic [1:0] PTR_HYST = 2'h2;
	localparam logic [1:0] PTR_UPPER = 2'h3;
	localparam logic [1:0] PTR_RST = 2'h0;
	localparam logic [15:0] READING_RST = 16'h0000;
	localparam logic [7:0] SETUP_RST = 8'h28;
	localparam logic [15:0] HYST_RST = 16'h4B00;
	localparam logic [15:0] UPPER_RST = 16'h5000;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SETUP_TRIGGER = 7;
	localparam int PERIOD_HI = 6;
	localparam int PERIOD_LO = 5;
	localparam int FAULT_HI = 4;
	localparam int FAULT_LO = 3;
	localparam int SENSE_BIT = 2;
	localparam int LATCH_BIT = 1;
	localparam int PDOWN_BIT = 0;
	localparam int VAL_MSB = 15;
	localparam int VAL_LSB = 4;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam real CLK_MHZ = 25.0;
	localparam real CONV0_MS = 27.5;
	localparam real CONV1_MS = 55.0;
	localparam real CONV2_MS = 110.0;
	localparam real CONV3_MS = 220.0;
	localparam int CNT_W = 23;

	typedef enum logic [0:0] {
		TSRC_IDLE = 1'b0,
		TSRC_CONV = 1'b1
	} tsrc_conv_e;

	// Consecutive faults needed per field code
	function automatic logic [2:0] tsrc_fault_need(input logic [1:0] sel);
		case (sel)
			2'h0: tsrc_fault_need = 3'h1;
			2'h1: tsrc_fault_need = 3'h2;
			2'h2: tsrc_fault_need = 3'h4;
			default: tsrc_fault_need = 3'h6;
		endcase
	endfunction : tsrc_fault_need
endpackage : tsrc_pkg

// File: rtl/tsrc_conv_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tsrc_conv_timer #(
	parameter int CYC0 = 687500,
	parameter int CYC1 = 1375000,
	parameter int CYC2 = 2750000,
	parameter int CYC3 = 5500000
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Control
	input wire logic power_down_in,
	input wire logic oneshot_in,
	input wire logic [1:0] period_sel_in,
	// Status
	output logic done_out,
	output logic busy_out
);
	import tsrc_pkg::*;

	typedef struct packed {
		tsrc_conv_e st;
		logic [CNT_W-1:0] cnt;
		logic done;
	} tsrc_tmr_s;

	tsrc_tmr_s s;
	tsrc_tmr_s next_s;
	logic [CNT_W-1:0] load;

	// Period latched at start; a mid-conversion change waits for the next one
	always_comb begin
		case (period_sel_in)
			2'h0: load = CNT_W'(CYC0 - 1);
			2'h1: load = CNT_W'(CYC1 - 1);
			2'h2: load = CNT_W'(CYC2 - 1);
			default: load = CNT_W'(CYC3 - 1);
		endcase
	end

	// Idle until enabled, count down, pulse done at the end
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		case (s.st)
			TSRC_IDLE: begin
				if (!power_down_in || oneshot_in) begin
					next_s.st = TSRC_CONV;
					next_s.cnt = load;
				end
			end
			default: begin
				if (s.cnt == '0) begin
					next_s.done = 1'b1;
					if (power_down_in) begin
						next_s.st = TSRC_IDLE;
					end else begin
						next_s.cnt = load;
					end
				end else begin
					next_s.cnt = s.cnt - 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '{st: TSRC_IDLE, cnt: '0, done: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign done_out = s.done;
	assign busy_out = (s.st == TSRC_CONV);

	chk_conv_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(s.st == TSRC_CONV && s.cnt == '0 && !power_down_in) |=> busy_out && s.cnt == $past(load))
		else $error("conversion did not restart");
	chk_pdown_stop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(s.st == TSRC_CONV && s.cnt == '0 && power_down_in) |=> done_out && !busy_out)
		else $error("power-down did not stop conversions");
endmodule : tsrc_conv_timer
`default_nettype wire

// File: rtl/tsrc_alert_engine.sv
`timescale 1ns/1ps
`default_nettype none
module tsrc_alert_engine (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// New result and limits
	input wire logic done_in,
	input wire logic signed [11:0] sample_in,
	input wire logic signed [11:0] low_in,
	input wire logic signed [11:0] high_in,
	// Setup
	input wire logic [2:0] need_in,
	input wire logic latch_mode_in,
	input wire logic clear_in,
	// Alert, active true
	output logic alert_out
);
	import tsrc_pkg::*;

	typedef struct packed {
		logic alert;
		logic watch_low;
		logic mode;
		logic [2:0] cnt;
	} tsrc_alr_s;

	tsrc_alr_s s;
	tsrc_alr_s next_s;
	logic fault;
	logic trip;
	logic low_side;

	// Fault queue: consecutive out-of-limit results only
	always_comb begin
		low_side = s.mode ? s.watch_low : s.alert;
		fault = low_side ? (sample_in < low_in) : (sample_in >= high_in);
		trip = done_in && fault && (s.cnt + 3'h1 >= need_in);
		next_s = s;
		next_s.mode = latch_mode_in;
		if (done_in) begin
			next_s.cnt = fault ? s.cnt + 3'h1 : 3'h0;
		end
		if (trip) begin
			next_s.cnt = 3'h0;
			if (s.mode) begin
				next_s.alert = 1'b1;
				next_s.watch_low = !s.watch_low;
			end else begin
				next_s.alert = !s.alert;
			end
		end else if (s.mode && clear_in) begin
			next_s.alert = 1'b0;
		end
		// Leaving interrupt behaviour wipes the internal state
		if (s.mode && !latch_mode_in) begin
			next_s.alert = 1'b0;
			next_s.watch_low = 1'b0;
			next_s.cnt = 3'h0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign alert_out = s.alert;

	chk_alert_cause: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$changed(alert_out) && !$fell(s.mode) && !(s.mode && $past(clear_in)) |-> $past(done_in))
		else $error("alert changed without a conversion");
	chk_int_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(s.mode && latch_mode_in && clear_in && !done_in) |=> !alert_out)
		else $error("interrupt alert not cleared");
	chk_single_fault: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(need_in == 3'h1 && done_in && !s.mode && !latch_mode_in && !s.alert
		&& sample_in >= high_in) |=> alert_out)
		else $error("single fault did not raise alert");
endmodule : tsrc_alert_engine
`default_nettype wire

// File: rtl/tsrc_core.sv
`timescale 1ns/1ps
`default_nettype none
module tsrc_core #(
	parameter int CONV_CYC0 = $rtoi(tsrc_pkg::CONV0_MS * 1000.0 * tsrc_pkg::CLK_MHZ),
	parameter int CONV_CYC1 = $rtoi(tsrc_pkg::CONV1_MS * 1000.0 * tsrc_pkg::CLK_MHZ),
	parameter int CONV_CYC2 = $rtoi(tsrc_pkg::CONV2_MS * 1000.0 * tsrc_pkg::CLK_MHZ),
	parameter int CONV_CYC3 = $rtoi(tsrc_pkg::CONV3_MS * 1000.0 * tsrc_pkg::CLK_MHZ)
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// Register command from the bus engine
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic cmd_ptr_valid_in,
	input wire logic [7:0] cmd_ptr_in,
	input wire logic [15:0] cmd_wdata_in,
	input wire logic alert_ack_in,
	// Converter result
	input wire logic [11:0] sample_in,
	// Read answer and alert pin
	output logic [15:0] rd_data_out,
	output logic rd_valid_out,
	output logic alert_out
);
	import tsrc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] ptr;
		logic [11:0] reading;
		logic [6:0] setup;
		logic [11:0] hyst;
		logic [11:0] upper;
		logic [15:0] rd_data;
		logic rd_valid;
		logic alert;
	} tsrc_core_s;

	tsrc_core_s s;
	tsrc_core_s next_s;
	logic rst_meta;
	logic rst_n;
	logic [1:0] eff_ptr;
	logic wr_setup;
	logic oneshot;
	logic conv_done;
	logic conv_busy;
	logic alert_level;
	logic alert_clear;
	logic power_down;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	// Two stages so release never lands near a clock edge
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// Upper six pointer bits carry nothing and are dropped
	assign eff_ptr = cmd_ptr_valid_in ? cmd_ptr_in[1:0] : s.ptr;
	assign power_down = s.setup[PDOWN_BIT];
	assign wr_setup = cmd_valid_in && cmd_write_in && eff_ptr == PTR_SETUP;
	// Trigger only counts when the written byte keeps power-down set
	assign oneshot = wr_setup && cmd_wdata_in[8 + SETUP_TRIGGER] && cmd_wdata_in[8 + PDOWN_BIT];
	// Any read, an acknowledge, or the final conversion before sleep
	assign alert_clear = (cmd_valid_in && !cmd_write_in) || alert_ack_in
		|| (conv_done && power_down);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.rd_valid = 1'b0;
		if (cmd_valid_in) begin
			if (cmd_ptr_valid_in) begin
				next_s.ptr = cmd_ptr_in[1:0];
			end
			if (cmd_write_in) begin
				// Setup takes the first byte; the trigger bit is never stored
				if (eff_ptr == PTR_SETUP) begin
					next_s.setup = cmd_wdata_in[14:8];
				end else if (eff_ptr == PTR_HYST) begin
					next_s.hyst = cmd_wdata_in[VAL_MSB:VAL_LSB];
				end else if (eff_ptr == PTR_UPPER) begin
					next_s.upper = cmd_wdata_in[VAL_MSB:VAL_LSB];
				end
				// Reading register writes fall through untouched
			end else begin
				next_s.rd_valid = 1'b1;
				if (eff_ptr == PTR_READING) begin
					next_s.rd_data = {s.reading, 4'h0};
				end else if (eff_ptr == PTR_SETUP) begin
					next_s.rd_data = {1'b0, s.setup, 8'h00};
				end else if (eff_ptr == PTR_HYST) begin
					next_s.rd_data = {s.hyst, 4'h0};
				end else begin
					next_s.rd_data = {s.upper, 4'h0};
				end
			end
		end
		if (conv_done) begin
			next_s.reading = sample_in;
		end
		// Pin level follows sense; active low by default
		next_s.alert = s.setup[SENSE_BIT] ? alert_level : !alert_level;
	end

	// Reset values are constants; reading starts at zero degrees
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s.ptr <= PTR_RST;
			s.reading <= READING_RST[VAL_MSB:VAL_LSB];
			s.setup <= SETUP_RST[6:0];
			s.hyst <= HYST_RST[VAL_MSB:VAL_LSB];
			s.upper <= UPPER_RST[VAL_MSB:VAL_LSB];
			s.rd_data <= 16'h0000;
			s.rd_valid <= 1'b0;
			s.alert <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign rd_data_out = s.rd_data;
	assign rd_valid_out = s.rd_valid;
	assign alert_out = s.alert;

	// ----------------------------------------------------------------
	// Conversion timing and alert logic
	// ----------------------------------------------------------------
	tsrc_conv_timer #(
		.CYC0(CONV_CYC0),
		.CYC1(CONV_CYC1),
		.CYC2(CONV_CYC2),
		.CYC3(CONV_CYC3)
	) u_timer (
		.clk_in(sys_clk_in),
		.rst_n_in(rst_n),
		.power_down_in(power_down),
		.oneshot_in(oneshot),
		.period_sel_in(s.setup[PERIOD_HI:PERIOD_LO]),
		.done_out(conv_done),
		.busy_out(conv_busy)
	);

	tsrc_alert_engine u_alert (
		.clk_in(sys_clk_in),
		.rst_n_in(rst_n),
		.done_in(conv_done),
		.sample_in(sample_in),
		.low_in(s.hyst),
		.high_in(s.upper),
		.need_in(tsrc_fault_need(s.setup[FAULT_HI:FAULT_LO])),
		.latch_mode_in(s.setup[LATCH_BIT]),
		.clear_in(alert_clear),
		.alert_out(alert_level)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence seq_ptr_cmd;
		cmd_valid_in && cmd_ptr_valid_in;
	endsequence

	sequence seq_bare_read;
		cmd_valid_in && !cmd_write_in && !cmd_ptr_valid_in;
	endsequence

	// Commands never come back to back from the controller, so check the latch alone
	chk_ptr_latch: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		seq_ptr_cmd |=> s.ptr == $past(cmd_ptr_in[1:0]))
		else $error("pointer byte not latched");
	chk_reading_ro: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(cmd_valid_in && cmd_write_in && eff_ptr == PTR_READING && !conv_done)
		|=> $stable(s.reading))
		else $error("write changed the reading register");
	chk_read_layout: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(cmd_valid_in && !cmd_write_in && eff_ptr == PTR_READING)
		|=> rd_valid_out && rd_data_out == {$past(s.reading), 4'h0})
		else $error("reading bytes misplaced");
	chk_trigger_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(cmd_valid_in && !cmd_write_in && eff_ptr == PTR_SETUP) |=> rd_data_out[15] == 1'b0)
		else $error("trigger bit read back as one");
	chk_reading_update: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		conv_done |=> s.reading == $past(sample_in))
		else $error("result not stored after conversion");
	chk_alert_sense: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		##1 alert_out == ($past(s.setup[SENSE_BIT]) ~^ $past(alert_level)))
		else $error("alert pin polarity wrong");
	chk_conv_busy: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(!power_down && !conv_busy) |=> conv_busy)
		else $error("continuous conversion stalled");

	// ----------------------------------------------------------------
	// Register file checks
	// ----------------------------------------------------------------
	// A bare read must come from the latched pointer; the reading is the
	// case that matters after power-up
	chk_bare_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(cmd_valid_in && !cmd_write_in && !cmd_ptr_valid_in && s.ptr == PTR_READING)
		|=> rd_valid_out && rd_data_out == {$past(s.reading), 4'h0})
		else $error("bare read ignored the latched pointer");

	// Setup keeps the upper byte only; the trigger bit is dropped
	chk_setup_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		wr_setup |=> s.setup == $past(cmd_wdata_in[14:8]))
		else $error("setup write not stored");

	// Limits keep the twelve value bits; the low nibble is discarded
	chk_hyst_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(cmd_valid_in && cmd_write_in && eff_ptr == PTR_HYST)
		|=> s.hyst == $past(cmd_wdata_in[VAL_MSB:VAL_LSB]))
		else $error("lower limit write not stored");

	// Same layout as the lower limit
	chk_upper_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(cmd_valid_in && cmd_write_in && eff_ptr == PTR_UPPER)
		|=> s.upper == $past(cmd_wdata_in[VAL_MSB:VAL_LSB]))
		else $error("upper limit write not stored");

	// Read strobe is a single pulse, only after a read command
	chk_rd_pulse: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		!(cmd_valid_in && !cmd_write_in) |=> !rd_valid_out)
		else $error("read valid without a read");

	// Read data must hold between reads so a slow collector still sees it
	chk_rd_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		!(cmd_valid_in && !cmd_write_in) |=> $stable(rd_data_out))
		else $error("read data moved without a read");

	// Setup reads back in the upper byte, trigger as zero
	chk_setup_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(cmd_valid_in && !cmd_write_in && eff_ptr == PTR_SETUP)
		|=> rd_data_out == {1'b0, $past(s.setup), 8'h00})
		else $error("setup read layout wrong");

	// Limits read back in the same layout as the reading
	chk_hyst_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(cmd_valid_in && !cmd_write_in && eff_ptr == PTR_HYST)
		|=> rd_data_out == {$past(s.hyst), 4'h0})
		else $error("lower limit read wrong");

	chk_upper_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(cmd_valid_in && !cmd_write_in && eff_ptr == PTR_UPPER)
		|=> rd_data_out == {$past(s.upper), 4'h0})
		else $error("upper limit read wrong");

	// The low nibble is always zero whatever register is read
	chk_low_nibble: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		rd_valid_out |-> rd_data_out[3:0] == 4'h0)
		else $error("low nibble of read data not zero");

	// ----------------------------------------------------------------
	// Conversion control checks
	// ----------------------------------------------------------------
	// A trigger while asleep must start exactly one conversion
	chk_oneshot_start: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(oneshot && !conv_busy) |=> conv_busy)
		else $error("one-shot did not start a conversion");

	// Asleep with no trigger the converter stays idle
	chk_pdown_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		(power_down && !conv_busy && !oneshot) |=> !conv_busy)
		else $error("conversion started while powered down");

	// The reading only moves at the end of a conversion, so it reads
	// zero degrees until the first one finishes
	chk_reading_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		!conv_done |=> $stable(s.reading))
		else $error("reading changed without a conversion");
endmodule : tsrc_core
`default_nettype wire

// File: testbench/tsrc_bus_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tsrc_bus_ctrl (
	// Clock
	input wire logic clk_in,
	// Command side
	output logic cmd_valid_out,
	output logic cmd_write_out,
	output logic cmd_ptr_valid_out,
	output logic [7:0] cmd_ptr_out,
	output logic [15:0] cmd_wdata_out,
	// Answer side
	input wire logic [15:0] rd_data_in,
	input wire logic rd_valid_in
);
	// Idle bus at time zero
	initial begin
		cmd_valid_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_ptr_valid_out = 1'b0;
		cmd_ptr_out = 8'h00;
		cmd_wdata_out = 16'h0000;
	end

	// One command, held for exactly the taking edge
	task automatic issue(input logic wr, input logic pv, input logic [7:0] ptr,
			input logic [15:0] data);
		@(posedge clk_in);
		cmd_valid_out <= 1'b1;
		cmd_write_out <= wr;
		cmd_ptr_valid_out <= pv;
		cmd_ptr_out <= ptr;
		cmd_wdata_out <= data;
		@(posedge clk_in);
		cmd_valid_out <= 1'b0;
		// Released pointer and data lines flip so stale values never look valid
		cmd_ptr_out <= ~ptr;
		cmd_wdata_out <= ~data;
	endtask : issue

	// Writes always carry the pointer byte
	task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
		issue(1'b1, 1'b1, ptr, data);
	endtask : wr

	// Read; caller decides whether the pointer byte is sent
	task automatic rd(input logic pv, input logic [7:0] ptr, output logic [15:0] data);
		data = 16'hXXXX;
		issue(1'b0, pv, ptr, 16'h0000);
		#1;
		// Both bytes are taken as one word, upper byte first
		if (rd_valid_in === 1'b1) begin
			data = rd_data_in;
		end
	endtask : rd
endmodule : tsrc_bus_ctrl
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic alert_ack_in = 1'b0;
	logic [11:0] sample_in = 12'h7FF;
	logic cmd_valid, cmd_write, cmd_ptr_valid, rd_valid, alert_out;
	logic [7:0] cmd_ptr;
	logic [15:0] cmd_wdata, rd_data, got;
	int mismatches = 0;
	int compares = 0;
	int need;

	// ----------------------------------------------------------------
	// Clock, design and controller model
	// ----------------------------------------------------------------
	always #20 sys_clk_in = ~sys_clk_in;

	// Short conversion periods keep the run brief
	tsrc_core #(.CONV_CYC0(8), .CONV_CYC1(16), .CONV_CYC2(32), .CONV_CYC3(64)) dut (
		.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid),
		.cmd_write_in(cmd_write), .cmd_ptr_valid_in(cmd_ptr_valid), .cmd_ptr_in(cmd_ptr),
		.cmd_wdata_in(cmd_wdata), .alert_ack_in(alert_ack_in), .sample_in(sample_in),
		.rd_data_out(rd_data), .rd_valid_out(rd_valid), .alert_out(alert_out)
	);

	tsrc_bus_ctrl ctl (
		.clk_in(sys_clk_in), .cmd_valid_out(cmd_valid), .cmd_write_out(cmd_write),
		.cmd_ptr_valid_out(cmd_ptr_valid), .cmd_ptr_out(cmd_ptr),
		.cmd_wdata_out(cmd_wdata), .rd_data_in(rd_data), .rd_valid_in(rd_valid)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic rdc(input string what, input logic pv, input logic [7:0] ptr,
			input logic [15:0] exp);
		ctl.rd(pv, ptr, got);
		chk(what, exp, got);
	endtask : rdc

	// Settle past the edge before looking at the pin
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask : wait_cyc

	task automatic set_sample(input logic [11:0] v);
		@(posedge sys_clk_in);
		sample_in <= v;
	endtask : set_sample

	task automatic tally_and_finish;
		$display("Counts: %0d mismatches in %0d compares", mismatches, compares);
		if (mismatches == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		// Reset values, read before the first conversion ends
		rdc("bare reading", 1'b0, 8'h00, 16'h0000);
		rdc("setup reset", 1'b1, 8'h01, 16'h2800);
		rdc("lower reset", 1'b1, 8'h02, 16'h4B00);
		rdc("upper reset", 1'b1, 8'h03, 16'h5000);
		rdc("bare repeat", 1'b0, 8'h00, 16'h5000);
		wait_cyc(20);
		rdc("first result", 1'b1, 8'h00, 16'h7FF0);
		// Trigger bit never reads back; reading register refuses writes
		ctl.wr(8'h01, 16'hE800);
		rdc("setup trigger", 1'b1, 8'h01, 16'h6800);
		ctl.wr(8'h00, 16'h1234);
		rdc("reading kept", 1'b1, 8'h00, 16'h7FF0);
		// Only the two low pointer bits select; low nibble is dropped
		ctl.wr(8'hFE, 16'h4C3F);
		rdc("ptr low bits", 1'b1, 8'h02, 16'h4C30);
		// Every fault count, comparator mode, equal-to-limit trip
		for (int f = 0; f < 4; f++) begin
			set_sample(12'h000);
			ctl.wr(8'h01, {3'b000, f[1:0], 3'b000, 8'h00});
			wait_cyc(100);
			chk("alert cooled", 16'h0001, {15'h0, alert_out});
			need = (f == 0) ? 1 : (f == 1) ? 2 : (f == 2) ? 4 : 6;
			set_sample(12'h500);
			wait_cyc((need - 1) * 8 + 1);
			chk("alert early", 16'h0001, {15'h0, alert_out});
			// Last fault may land up to one full period after the early look
			wait_cyc(8);
			chk("alert raised", 16'h0000, {15'h0, alert_out});
		end
		// Sense bit flips the active level
		ctl.wr(8'h01, 16'h1C00);
		wait_cyc(4);
		chk("alert high", 16'h0001, {15'h0, alert_out});
		// Interrupt behaviour: read clears, cold trips, acknowledge clears
		ctl.wr(8'h01, 16'h0A00);
		wait_cyc(40);
		chk("int raised", 16'h0000, {15'h0, alert_out});
		ctl.rd(1'b1, 8'h02, got);
		wait_cyc(4);
		chk("int read clr", 16'h0001, {15'h0, alert_out});
		wait_cyc(40);
		chk("int no rearm", 16'h0001, {15'h0, alert_out});
		set_sample(12'h000);
		wait_cyc(40);
		chk("int cold", 16'h0000, {15'h0, alert_out});
		@(posedge sys_clk_in);
		alert_ack_in <= 1'b1;
		@(posedge sys_clk_in);
		alert_ack_in <= 1'b0;
		wait_cyc(4);
		chk("int ack clr", 16'h0001, {15'h0, alert_out});
		// Power-down finishes the running conversion, then one-shot
		set_sample(12'h111);
		wait_cyc(20);
		ctl.wr(8'h01, 16'h0100);
		wait_cyc(20);
		set_sample(12'h222);
		wait_cyc(40);
		rdc("pdown hold", 1'b1, 8'h00, 16'h1110);
		ctl.wr(8'h01, 16'h8100);
		wait_cyc(30);
		rdc("one shot", 1'b1, 8'h00, 16'h2220);
		set_sample(12'h333);
		wait_cyc(40);
		rdc("back down", 1'b0, 8'h00, 16'h2220);
		tally_and_finish();
	end

	// Whole sequence needs about 900 cycles
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		mismatches++;
		$display("ERROR watchdog expected done seen timeout");
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
